//--- data_side_mem_pkg.sv
// Constants and carrier types for the data-side on-chip memory port
package data_side_mem_pkg;

    // ==========================================================
    // Address and data layout, bit 0 is the most significant bit
    // ==========================================================
    localparam int ADDR_W        = 32;
    localparam int REGION_MSB    = 0;
    localparam int REGION_LSB    = 7;
    localparam int WORD_MSB      = 8;
    localparam int WORD_LSB      = 29;
    localparam int WORD_ADDR_W   = WORD_LSB - WORD_MSB + 1;
    localparam int DATA_W        = 32;
    localparam int LANES         = DATA_W / 8;
    localparam int CTRL_W        = 8;
    localparam int DECODE_EN_BIT = 0;

    // ==========================================================
    // Reset values and crossing depth
    // ==========================================================
    localparam logic [0:CTRL_W-1] BASE_RESET = 8'h00;
    localparam logic [0:CTRL_W-1] CTRL_RESET = 8'h00;
    localparam logic [0:LANES-1]  ALL_LANES  = 4'hf;
    localparam int SYNC_STAGES = 3;
    localparam int RESET_STAGES = 2;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {PORT_IDLE, PORT_STROBE, PORT_WAIT} port_state_e;

    typedef struct packed {
        logic                   write;
        logic [0:WORD_ADDR_W-1] addr;
        logic [0:DATA_W-1]      data;
        logic [0:LANES-1]       be;
    } mem_cmd_s;

    typedef struct packed {
        logic [0:CTRL_W-1]        region_base_reg;
        logic [0:CTRL_W-1]        port_control_reg;
        logic                     ld_v;
        logic [0:WORD_ADDR_W-1]   ld_addr;
        logic                     st_v;
        mem_cmd_s                 st;
        logic                     busy;
        mem_cmd_s                 cmd;
        logic                     req_tgl;
        logic [SYNC_STAGES-1:0]   ack_sync;
        logic                     ack_seen;
        logic                     ld_ready;
        logic                     st_ready;
        logic                     rsp_valid;
        logic                     rsp_miss;
        logic [0:DATA_W-1]        rsp_data;
    } cpu_state_s;

    typedef struct packed {
        logic [SYNC_STAGES-1:0] req_sync;
        logic                   req_seen;
        port_state_e            state;
        logic                   ack_tgl;
        logic                   mem_enable;
        mem_cmd_s               out;
        logic [0:DATA_W-1]      rdata;
    } port_state_s;

endpackage

//--- data_side_mem_port.sv
// Data-side memory port: load/store queue on clk, access strobe on data_port_clock
module data_side_mem_port (
    input  wire logic                                         clk,
    input  wire logic                                         resetn,
    input  wire logic                                         data_port_clock,
    input  wire logic [0:data_side_mem_pkg::CTRL_W-1]         region_base_value,
    input  wire logic [0:data_side_mem_pkg::CTRL_W-1]         port_control_value,
    input  wire logic                                         req_valid,
    input  wire logic                                         req_write,
    input  wire logic [0:data_side_mem_pkg::ADDR_W-1]         req_addr,
    input  wire logic [0:data_side_mem_pkg::DATA_W-1]         req_write_data,
    input  wire logic [0:data_side_mem_pkg::LANES-1]          req_be,
    output logic                                              load_ready,
    output logic                                              store_ready,
    output logic                                              rsp_valid,
    output logic                                              rsp_miss,
    output logic [0:data_side_mem_pkg::DATA_W-1]              rsp_data,
    output logic                                              mem_enable,
    output logic [0:data_side_mem_pkg::WORD_ADDR_W-1]         mem_word_address,
    output logic [0:data_side_mem_pkg::DATA_W-1]              mem_write_data,
    output logic [0:data_side_mem_pkg::LANES-1]               mem_byte_we,
    input  wire logic [0:data_side_mem_pkg::DATA_W-1]         port_read_data,
    input  wire logic                                         access_done
);

    // ==========================================================
    // Reset release, one copy per clock domain
    // ==========================================================
    logic [data_side_mem_pkg::RESET_STAGES-1:0] cpu_rst_reg;
    logic [data_side_mem_pkg::RESET_STAGES-1:0] port_rst_reg;
    logic                                       cpu_rst_n;
    logic                                       port_rst_n;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cpu_rst_reg <= '0;
        end else begin
            cpu_rst_reg <= {cpu_rst_reg[0], 1'b1};
        end
    end

    always_ff @(posedge data_port_clock or negedge resetn) begin
        if (!resetn) begin
            port_rst_reg <= '0;
        end else begin
            port_rst_reg <= {port_rst_reg[0], 1'b1};
        end
    end

    assign cpu_rst_n  = cpu_rst_reg[1];
    assign port_rst_n = port_rst_reg[1];

    // ==========================================================
    // Processor side
    // ==========================================================
    data_side_mem_pkg::cpu_state_s  cpu_reg;
    data_side_mem_pkg::cpu_state_s  cpu_next;
    data_side_mem_pkg::port_state_s port_reg;
    data_side_mem_pkg::port_state_s port_next;

    logic                                         hit;
    logic                                         take_ld;
    logic                                         take_st;
    logic                                         fwd;
    logic                                         ack_evt;
    logic [0:data_side_mem_pkg::WORD_ADDR_W-1]    waddr;

    assign waddr   = req_addr[data_side_mem_pkg::WORD_MSB:data_side_mem_pkg::WORD_LSB];
    assign hit     = cpu_reg.port_control_reg[data_side_mem_pkg::DECODE_EN_BIT]
                     && req_addr[data_side_mem_pkg::REGION_MSB:data_side_mem_pkg::REGION_LSB]
                        == cpu_reg.region_base_reg;
    assign take_ld = req_valid && !req_write && cpu_reg.ld_ready;
    assign take_st = req_valid && req_write && cpu_reg.st_ready;
    assign fwd     = cpu_reg.st_v && cpu_reg.st.addr == waddr
                     && cpu_reg.st.be == data_side_mem_pkg::ALL_LANES;
    assign ack_evt = cpu_reg.ack_sync[1] == cpu_reg.ack_sync[2]
                     && cpu_reg.ack_sync[2] != cpu_reg.ack_seen;

    always_comb begin
        cpu_next                  = cpu_reg;
        cpu_next.region_base_reg  = region_base_value;
        cpu_next.port_control_reg = port_control_value;
        cpu_next.rsp_valid        = 1'b0;
        cpu_next.rsp_miss         = 1'b0;
        cpu_next.ack_sync         = {cpu_reg.ack_sync[1:0], port_reg.ack_tgl};
        // Completion returned from the port domain frees the port
        if (ack_evt) begin
            cpu_next.ack_seen = cpu_reg.ack_sync[2];
            cpu_next.busy     = 1'b0;
            if (!cpu_reg.cmd.write) begin
                cpu_next.rsp_valid = 1'b1;
                cpu_next.rsp_data  = port_reg.rdata;
            end
        end
        // Issue: load first unless a store to the same word waits
        if (!cpu_reg.busy) begin
            if (cpu_reg.ld_v && !(cpu_reg.st_v && cpu_reg.st.addr == cpu_reg.ld_addr)) begin
                cpu_next.cmd.write = 1'b0;
                cpu_next.cmd.addr  = cpu_reg.ld_addr;
                cpu_next.cmd.data  = '0;
                cpu_next.cmd.be    = '0;
                cpu_next.ld_v      = 1'b0;
                cpu_next.busy      = 1'b1;
                cpu_next.req_tgl   = !cpu_reg.req_tgl;
            end else if (cpu_reg.st_v) begin
                cpu_next.cmd     = cpu_reg.st;
                cpu_next.st_v    = 1'b0;
                cpu_next.busy    = 1'b1;
                cpu_next.req_tgl = !cpu_reg.req_tgl;
            end
        end
        // Accept
        if ((take_ld || take_st) && !hit) begin
            cpu_next.rsp_miss = 1'b1;
        end else if (take_st) begin
            cpu_next.st_v       = 1'b1;
            cpu_next.st.write   = 1'b1;
            cpu_next.st.addr    = waddr;
            cpu_next.st.data    = req_write_data;
            cpu_next.st.be      = req_be;
        end else if (take_ld) begin
            if (fwd) begin
                cpu_next.rsp_valid = 1'b1;
                cpu_next.rsp_data  = cpu_reg.st.data;
            end else begin
                cpu_next.ld_v    = 1'b1;
                cpu_next.ld_addr = waddr;
            end
        end
        // A load in flight blocks new loads so answers stay in order
        cpu_next.ld_ready = !cpu_next.ld_v && !(cpu_next.busy && !cpu_next.cmd.write);
        // A queued load holds off new stores so no later store overtakes it
        cpu_next.st_ready = !cpu_next.st_v && !cpu_next.ld_v;
    end

    always_ff @(posedge clk or negedge cpu_rst_n) begin
        if (!cpu_rst_n) begin
            cpu_reg                  <= '0;
            cpu_reg.region_base_reg  <= data_side_mem_pkg::BASE_RESET;
            cpu_reg.port_control_reg <= data_side_mem_pkg::CTRL_RESET;
        end else begin
            cpu_reg <= cpu_next;
        end
    end

    // ==========================================================
    // Port side, on the port clock
    // ==========================================================
    logic req_evt;

    assign req_evt = port_reg.req_sync[1] == port_reg.req_sync[2]
                     && port_reg.req_sync[2] != port_reg.req_seen;

    always_comb begin
        port_next            = port_reg;
        port_next.mem_enable = 1'b0;
        port_next.req_sync   = {port_reg.req_sync[1:0], cpu_reg.req_tgl};
        case (port_reg.state)
            data_side_mem_pkg::PORT_IDLE: begin
                // Command fields are held stable while the request is in flight
                if (req_evt) begin
                    port_next.req_seen   = port_reg.req_sync[2];
                    port_next.out        = cpu_reg.cmd;
                    port_next.mem_enable = 1'b1;
                    port_next.state      = data_side_mem_pkg::PORT_STROBE;
                end
            end
            data_side_mem_pkg::PORT_STROBE: begin
                port_next.state = data_side_mem_pkg::PORT_WAIT;
            end
            data_side_mem_pkg::PORT_WAIT: begin
                if (access_done) begin
                    if (!port_reg.out.write) begin
                        port_next.rdata = port_read_data;
                    end
                    port_next.ack_tgl = !port_reg.ack_tgl;
                    port_next.state   = data_side_mem_pkg::PORT_IDLE;
                end
            end
            default: begin
                port_next.state = data_side_mem_pkg::PORT_IDLE;
            end
        endcase
    end

    always_ff @(posedge data_port_clock or negedge port_rst_n) begin
        if (!port_rst_n) begin
            port_reg       <= '0;
            port_reg.state <= data_side_mem_pkg::PORT_IDLE;
        end else begin
            port_reg <= port_next;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign load_ready       = cpu_reg.ld_ready;
    assign store_ready      = cpu_reg.st_ready;
    assign rsp_valid        = cpu_reg.rsp_valid;
    assign rsp_miss         = cpu_reg.rsp_miss;
    assign rsp_data         = cpu_reg.rsp_data;
    assign mem_enable       = port_reg.mem_enable;
    assign mem_word_address = port_reg.out.addr;
    assign mem_write_data   = port_reg.out.data;
    assign mem_byte_we      = port_reg.out.be;

    // ==========================================================
    // Checks
    // ==========================================================
    sequence strobe_s;
        mem_enable ##1 !mem_enable ##1 !mem_enable;
    endsequence

    en_pulse_a: assert property (@(posedge data_port_clock) disable iff (!port_rst_n)
        $rose(mem_enable) |-> strobe_s) else $error("Enable not a single pulse");
    wait_done_a: assert property (@(posedge data_port_clock) disable iff (!port_rst_n)
        port_reg.state == data_side_mem_pkg::PORT_WAIT && !access_done |=> !mem_enable)
        else $error("Access started before completion");
    issue_hold_a: assert property (@(posedge clk) disable iff (!cpu_rst_n)
        cpu_reg.busy && !ack_evt |=> cpu_reg.busy && $stable(cpu_reg.cmd))
        else $error("Command changed while in flight");
    store_take_a: assert property (@(posedge clk) disable iff (!cpu_rst_n)
        take_st && hit |=> cpu_reg.st_v && cpu_reg.st.be == $past(req_be)
                           && cpu_reg.st.data == $past(req_write_data))
        else $error("Store not buffered with data and lanes");
    miss_a: assert property (@(posedge clk) disable iff (!cpu_rst_n)
        (take_ld || take_st) && !hit |=> rsp_miss && !cpu_reg.ld_v && !$rose(cpu_reg.st_v))
        else $error("Unmatched access was queued");
    decode_off_a: assert property (@(posedge clk) disable iff (!cpu_rst_n)
        take_ld && !cpu_reg.port_control_reg[data_side_mem_pkg::DECODE_EN_BIT] |=> rsp_miss)
        else $error("Access decoded while decoding disabled");
    load_first_a: assert property (@(posedge clk) disable iff (!cpu_rst_n)
        !cpu_reg.busy && cpu_reg.ld_v && cpu_reg.st_v && cpu_reg.ld_addr != cpu_reg.st.addr
        |=> cpu_reg.busy && !cpu_reg.cmd.write) else $error("Store issued before load");
    same_addr_a: assert property (@(posedge clk) disable iff (!cpu_rst_n)
        !cpu_reg.busy && cpu_reg.ld_v && cpu_reg.st_v && cpu_reg.ld_addr == cpu_reg.st.addr
        |=> cpu_reg.cmd.write) else $error("Same-address load passed store");
    forward_a: assert property (@(posedge clk) disable iff (!cpu_rst_n)
        take_ld && hit && fwd |=> rsp_valid && rsp_data == $past(cpu_reg.st.data))
        else $error("Forwarded data wrong");

endmodule // data_side_mem_port

//--- mem_model.sv
// Behavioural fabric memory on the port clock with programmable completion latency
module mem_model (
    input  wire logic        data_port_clock,
    input  wire logic        mem_enable,
    input  wire logic [0:21] mem_word_address,
    input  wire logic [0:31] mem_write_data,
    input  wire logic [0:3]  mem_byte_we,
    input  wire logic [3:0]  lat,
    input  wire logic        tie,
    output logic             access_done,
    output logic [0:31]      port_read_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [0:31] mem [0:15];
    logic [3:0]  idx;
    logic [3:0]  cnt;
    logic        busy;
    initial begin
        access_done = 1'b0;
        port_read_data = 32'h0;
        busy = 1'b0;
        for (int i = 0; i < 16; i++) mem[i] = 32'h0;
    end
    // ==========================================================
    // Access handling
    // ==========================================================
    always @(posedge data_port_clock) begin
        access_done <= tie;
        // Released bus toggles so stale data is never mistaken for an answer
        port_read_data <= ~port_read_data;
        if (mem_enable) begin
            idx <= mem_word_address[18:21];
            cnt <= lat;
            busy <= !tie;
            if (tie) port_read_data <= mem[mem_word_address[18:21]];
            for (int i = 0; i < 4; i++) begin
                if (mem_byte_we[i]) mem[mem_word_address[18:21]][8*i+:8] <= mem_write_data[8*i+:8];
            end
        end else if (busy) begin
            cnt <= cnt - 4'h1;
            if (cnt <= 4'h1) begin
                access_done <= 1'b1;
                port_read_data <= mem[idx];
                busy <= 1'b0;
            end
        end
    end
endmodule // mem_model

//--- tb_top.sv
// Self-checking bench for the data-side memory port
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic w; logic [0:31] a; logic [0:31] d; logic [0:3] b; logic miss;} row_s;
    logic clk = 1'b0, data_port_clock = 1'b0, resetn = 1'b0, tie = 1'b0;
    logic [0:7] region_base_value = 8'h40, port_control_value = 8'h80;
    logic req_valid = 1'b0, req_write = 1'b0;
    logic [0:31] req_addr = 32'h0, req_write_data = 32'h0, rsp_data, mem_write_data, port_read_data;
    logic [0:3] req_be = 4'h0, mem_byte_we;
    logic [0:21] mem_word_address, last_addr;
    logic load_ready, store_ready, rsp_valid, rsp_miss, mem_enable, access_done;
    logic [3:0] lat = 4'h2;
    logic [0:3] we_q[$];
    int err_total = 0, checked = 0, strobes = 0, exp_n = 0;
    row_s rows[8] = '{
        '{1'b1, 32'h40000010, 32'h11223344, 4'hf, 1'b0}, '{1'b0, 32'h40000010, 32'h11223344, 4'h0, 1'b0},
        '{1'b0, 32'h41000010, 32'h0, 4'h0, 1'b1}, '{1'b0, 32'h3f000010, 32'h0, 4'h0, 1'b1},
        '{1'b1, 32'h40000010, 32'haabbccdd, 4'ha, 1'b0}, '{1'b0, 32'h40000010, 32'haa22cc44, 4'h0, 1'b0},
        '{1'b1, 32'h40ffff3c, 32'hcafef00d, 4'h1, 1'b0}, '{1'b0, 32'h40ffff3c, 32'h0000000d, 4'h0, 1'b0}};
    always #10 clk = ~clk;
    initial #7 forever #40 data_port_clock = ~data_port_clock;
    data_side_mem_port uut (.clk, .resetn, .data_port_clock, .region_base_value, .port_control_value,
        .req_valid, .req_write, .req_addr, .req_write_data, .req_be, .load_ready, .store_ready,
        .rsp_valid, .rsp_miss, .rsp_data, .mem_enable, .mem_word_address, .mem_write_data,
        .mem_byte_we, .port_read_data, .access_done);
    mem_model fm (.data_port_clock, .mem_enable, .mem_word_address, .mem_write_data, .mem_byte_we,
        .lat, .tie, .access_done, .port_read_data);
    always @(posedge data_port_clock) begin
        if (mem_enable === 1'b1) begin
            strobes++;
            we_q.push_back(mem_byte_we);
            last_addr = mem_word_address;
        end
    end
    // ==========================================================
    // Compare, wait and drive tasks
    // ==========================================================
    task automatic check_data(string n, logic [0:31] e, logic [0:31] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_flag(string n, logic [0:3] e, logic [0:3] g);
        check_data(n, {28'h0, e}, {28'h0, g});
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic timed_out(string n);
        err_total++;
        $display("wrong value %s expected event seen timeout", n);
        end_sim();
    endtask
    task automatic issue(logic w, logic [0:31] a, logic [0:31] d, logic [0:3] b);
        int i;
        @(negedge clk);
        for (i = 0; i < 400 && (w ? store_ready : load_ready) !== 1'b1; i++) @(negedge clk);
        if (i == 400) timed_out("ready");
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_write_data <= d;
        req_be <= b;
        @(negedge clk);
        req_valid <= 1'b0;
    endtask
    task automatic wait_rsp(logic miss, logic [0:31] e);
        int i;
        for (i = 0; i < 400 && rsp_valid !== 1'b1 && rsp_miss !== 1'b1; i++) @(negedge clk);
        if (i == 400) timed_out("response");
        check_flag("miss", {3'h0, miss}, {3'h0, rsp_miss});
        if (!miss) check_data("load data", e, rsp_data);
    endtask
    task automatic wait_strobes(int n);
        int i;
        for (i = 0; i < 400 && strobes < n; i++) @(negedge clk);
        if (i == 400) timed_out("strobe");
    endtask
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (3) @(negedge clk);
        check_flag("outputs in reset", 4'h0, {load_ready, store_ready, mem_enable, rsp_valid});
        resetn <= 1'b1;
        $display("reset test done");
        foreach (rows[k]) begin
            issue(rows[k].w, rows[k].a, rows[k].d, rows[k].b);
            if (!rows[k].miss) exp_n++;
            if (rows[k].w) wait_strobes(exp_n);
            else wait_rsp(rows[k].miss, rows[k].d);
            check_data("strobe count", exp_n, strobes);
            if (!rows[k].miss) check_data("word address", {10'h0, rows[k].a[8:29]}, {10'h0, last_addr});
            if (!rows[k].miss) check_flag("lane enables", rows[k].b, we_q[$]);
            $display("row %0d done", k);
        end
        port_control_value <= 8'h00;
        repeat (3) @(negedge clk);
        issue(1'b0, 32'h40000010, 32'h0, 4'h0);
        wait_rsp(1'b1, 32'h0);
        port_control_value <= 8'h80;
        $display("decode disable test done");
        lat <= 4'h8;
        issue(1'b1, 32'h40000020, 32'h01020304, 4'hf);
        wait_strobes(exp_n + 1);
        issue(1'b1, 32'h40000024, 32'h05060708, 4'hf);
        issue(1'b0, 32'h40000010, 32'h0, 4'h0);
        wait_rsp(1'b0, 32'haa22cc44);
        wait_strobes(exp_n + 3);
        check_flag("load before store", 4'h0, we_q[$-1]);
        check_flag("late store", 4'hf, we_q[$]);
        $display("load priority test done");
        issue(1'b1, 32'h40000030, 32'h0, 4'hf);
        issue(1'b1, 32'h40000034, 32'h5a5a5a5a, 4'hf);
        issue(1'b0, 32'h40000034, 32'h0, 4'h0);
        wait_rsp(1'b0, 32'h5a5a5a5a);
        issue(1'b1, 32'h40000034, 32'h12340000, 4'hc);
        issue(1'b0, 32'h40000034, 32'h0, 4'h0);
        wait_rsp(1'b0, 32'h12345a5a);
        $display("same word reorder test done");
        tie <= 1'b1;
        issue(1'b1, 32'h40000038, 32'h0badcafe, 4'hf);
        issue(1'b0, 32'h40000038, 32'h0, 4'h0);
        wait_rsp(1'b0, 32'h0badcafe);
        issue(1'b0, 32'h40000024, 32'h0, 4'h0);
        wait_rsp(1'b0, 32'h05060708);
        $display("tied completion test done");
        resetn <= 1'b0;
        @(negedge clk);
        check_flag("outputs in reset", 4'h0, {load_ready, store_ready, mem_enable, rsp_valid});
        check_data("data in reset", 32'h0, rsp_data);
        repeat (2) @(negedge clk);
        resetn <= 1'b1;
        issue(1'b0, 32'h40000038, 32'h0, 4'h0);
        wait_rsp(1'b0, 32'h0badcafe);
        $display("mid-run reset test done");
        region_base_value <= 8'h3f;
        repeat (2) @(negedge clk);
        issue(1'b0, 32'h3f000010, 32'h0, 4'h0);
        wait_rsp(1'b0, 32'haa22cc44);
        issue(1'b0, 32'h40000010, 32'h0, 4'h0);
        wait_rsp(1'b1, 32'h0);
        $display("region move test done");
        end_sim();
    end
endmodule // tb_top
